/* ibc_pkg.sv */
// What this block does
// - controller logic runs only while controller_on is set; clearing it disables
// - while enabled, writing one sets start, stop and nak requests; zero never clears
// - as master, start request issues a start, cleared when sent or on disable
// - start waits until a byte sits in the data register or shift register
// - start during an outgoing byte waits until byte and acknowledge finish
// - with stop and start both pending, stop goes out before start
// - start during a slave transaction to us clears start, sets arbitration lost
// - stop request sends stop after current byte is sent or received
// - stop request clears after stop is sent or on disable
// - stop during a slave transaction is cleared without sending a stop
// - timer select ignored while enabled; when disabled, rate generator ticks at one
// - data-empty interrupt raised only when tx_empty_irq_enable is set
// - nak request answers next received byte with nak, cleared when sent or disabled
// - flush empties data register, sets tx_holding_empty; flush reads zero
// - input_spike_filter_on filters data and clock inputs, rejecting sub-cycle pulses
// - with filters on, filtered inputs lag by three system clocks
// - a software write to data_byte_reg clears tx_holding_empty
// - master drives one but samples zero sets arbitration_lost_flag; status read clears
//
// package of constants and carrier types for the bus control block.
// assumes an apb slave port with 32-bit data and word-aligned registers.
package ibc_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_DATA = 12'hF50;
  localparam logic [11:0] IDX_ISTAT = 12'hF51;
  localparam logic [11:0] IDX_CTRL = 12'hF52;
  localparam logic [11:0] IDX_RATE_HI = 12'hF53;
  localparam logic [11:0] IDX_RATE_LO = 12'hF54;
  localparam logic [11:0] IDX_EVENT = 12'hF56;
  localparam logic [11:0] IDX_MASK = 12'hF57;

  // ----------------------------------------------------------------
  // bus_control fields
  // ----------------------------------------------------------------
  localparam int CTL_ON = 7;
  localparam int CTL_START = 6;
  localparam int CTL_STOP = 5;
  localparam int CTL_TSEL = 4;
  localparam int CTL_TXI = 3;
  localparam int CTL_NAK = 2;
  localparam int CTL_FLUSH = 1;
  localparam int CTL_FILT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // irq_status_reg fields
  localparam int ST_TXE = 7;
  localparam int ST_ARB = 2;

  // event register fields (same layout for mask)
  localparam int EV_TXE = 0;
  localparam int EV_ARB = 1;
  localparam int EV_TICK = 2;
  localparam int EV_START = 3;
  localparam int EV_STOP = 4;
  localparam int EV_NAK = 5;
  localparam int EV_W = 6;
  localparam logic [EV_W-1:0] EV_RESET = 6'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 6'h00;

  // reset values
  localparam logic [15:0] RATE_RESET = 16'hFFFF;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FILT_LAG_CYC = 3;

  // status from the bus engine, same clock domain
  typedef struct packed {
    logic master;       // engine owns the bus as master
    logic slave_busy;   // slave transaction addressed to us underway
    logic shifting;     // a byte is being shifted out
    logic shift_loaded; // shift register holds a byte
    logic byte_done;    // pulse: byte plus acknowledge completed
    logic rx_byte;      // pulse: byte received
    logic start_done;   // pulse: start condition sent
    logic stop_done;    // pulse: stop condition sent
    logic nak_done;     // pulse: not-acknowledge sent
    logic load;         // pulse: engine took data into shift register
    logic sda_drive;    // value engine drives on the data line
  } ibc_eng_t;

  // commands to the bus engine
  typedef struct packed {
    logic issue_start;
    logic issue_stop;
    logic send_nak;
    logic on;
  } ibc_cmd_t;

endpackage

/* ibc_bus_control.sv */
// control logic of the two-wire bus controller: register file, requests,
// data holding register, rate timer, input filters and interrupt.
// assumes an apb master on pclk and a bus engine on pclk reporting via eng.
`timescale 1ns/100ps
module ibc_bus_control #(
  parameter int FILT_STAGES = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ibc_pkg::ibc_eng_t eng,
  output ibc_pkg::ibc_cmd_t cmd,
  output logic [7:0] tx_data,
  output logic tx_full,
  input wire logic sda_pin,
  input wire logic scl_pin,
  output logic sda_filt,
  output logic scl_filt,
  output logic scl_rise,
  output logic tick,
  output logic irq
);

  initial begin
    if (FILT_STAGES != ibc_pkg::FILT_LAG_CYC) $error("filter depth must be three");
  end

  // ----------------------------------------------------------------
  // register storage and apb decode
  // ----------------------------------------------------------------
  logic on, start_req, stop_req, tsel, tx_empty_irq_enable, nak_req, filt_on;
  logic [7:0] data_reg;
  logic tx_empty, arb_lost, stop_out;
  logic [15:0] rate_reload, rate_cnt;
  logic [ibc_pkg::EV_W-1:0] ev, ev_mask;
  logic acc, done, wr, rd, mapped;
  logic [11:0] idx;
  logic [7:0] wb;

  function automatic logic is_reg(input logic [11:0] i);
    is_reg = (i == ibc_pkg::IDX_DATA) || (i == ibc_pkg::IDX_ISTAT) || (i == ibc_pkg::IDX_CTRL) ||
             (i == ibc_pkg::IDX_RATE_HI) || (i == ibc_pkg::IDX_RATE_LO) ||
             (i == ibc_pkg::IDX_EVENT) || (i == ibc_pkg::IDX_MASK);
  endfunction

  assign acc = psel && penable;
  assign done = acc && pready;
  assign idx = paddr[13:2];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00) && is_reg(idx);
  assign wr = done && pwrite && mapped;
  assign rd = done && !pwrite && mapped;
  assign wb = pwdata[7:0];

  logic wr_ctrl, wr_data, rd_istat, rd_event;
  assign wr_ctrl = wr && (idx == ibc_pkg::IDX_CTRL);
  assign wr_data = wr && (idx == ibc_pkg::IDX_DATA);
  assign rd_istat = rd && (idx == ibc_pkg::IDX_ISTAT);
  assign rd_event = rd && (idx == ibc_pkg::IDX_EVENT);

  // one wait state: pready rises in the second access cycle, so the
  // read mux has a full cycle and prdata leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
    end
  end

  // read data captured one edge before the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (acc && !pready && !pwrite) begin
        prdata <= 32'h0000_0000;
        case (idx)
          ibc_pkg::IDX_DATA: prdata[7:0] <= data_reg;
          ibc_pkg::IDX_ISTAT: begin
            prdata[ibc_pkg::ST_TXE] <= tx_empty;
            prdata[ibc_pkg::ST_ARB] <= arb_lost;
          end
          // flush always reads zero
          ibc_pkg::IDX_CTRL: prdata[7:0] <= {on, start_req, stop_req, tsel, tx_empty_irq_enable, nak_req, 1'b0, filt_on};
          ibc_pkg::IDX_RATE_HI: prdata[7:0] <= rate_reload[15:8];
          ibc_pkg::IDX_RATE_LO: prdata[7:0] <= rate_reload[7:0];
          ibc_pkg::IDX_EVENT: prdata[ibc_pkg::EV_W-1:0] <= ev;
          ibc_pkg::IDX_MASK: prdata[ibc_pkg::EV_W-1:0] <= ev_mask;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // plain control bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on <= ibc_pkg::CTRL_RESET[ibc_pkg::CTL_ON];
      tsel <= ibc_pkg::CTRL_RESET[ibc_pkg::CTL_TSEL];
      tx_empty_irq_enable <= ibc_pkg::CTRL_RESET[ibc_pkg::CTL_TXI];
      filt_on <= ibc_pkg::CTRL_RESET[ibc_pkg::CTL_FILT];
    end else if (ce && wr_ctrl) begin
      on <= wb[ibc_pkg::CTL_ON];
      tsel <= wb[ibc_pkg::CTL_TSEL];
      tx_empty_irq_enable <= wb[ibc_pkg::CTL_TXI];
      filt_on <= wb[ibc_pkg::CTL_FILT];
    end
  end

  logic set_start, set_stop, set_nak, drop;
  // clearing the enable bit, even in the write itself, drops every request
  assign drop = !on || (wr_ctrl && !wb[ibc_pkg::CTL_ON]);
  // writes of one only count while enabled; zeros never clear
  assign set_start = wr_ctrl && on && wb[ibc_pkg::CTL_START];
  assign set_stop = wr_ctrl && on && wb[ibc_pkg::CTL_STOP];
  assign set_nak = wr_ctrl && on && wb[ibc_pkg::CTL_NAK];

  logic start_in_slave, stop_in_slave;
  assign start_in_slave = start_req && eng.slave_busy && !eng.master;
  assign stop_in_slave = stop_req && eng.slave_busy && !eng.master;

  // ----------------------------------------------------------------
  // start request
  // ----------------------------------------------------------------
  // disabling wins over everything; completion clears, a fresh write sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_req <= 1'b0;
    end else if (ce) begin
      if (drop) begin
        start_req <= 1'b0;
      end else if (set_start) begin
        start_req <= 1'b1;
      end else if (eng.start_done || start_in_slave) begin
        start_req <= 1'b0;
      end
    end
  end

  // stop request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_req <= 1'b0;
    end else if (ce) begin
      if (drop) begin
        stop_req <= 1'b0;
      end else if (set_stop) begin
        stop_req <= 1'b1;
      end else if (eng.stop_done || stop_in_slave) begin
        stop_req <= 1'b0;
      end
    end
  end

  // nak request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_req <= 1'b0;
    end else if (ce) begin
      if (drop) begin
        nak_req <= 1'b0;
      end else if (set_nak) begin
        nak_req <= 1'b1;
      end else if (eng.nak_done) begin
        nak_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // condition sequencing toward the engine
  // ----------------------------------------------------------------
  // a start needs a byte to send, no byte in flight and no stop pending;
  // stop_out keeps a start back until the engine has reported the stop
  logic start_go, stop_go;
  assign start_go = start_req && !eng.slave_busy && (!tx_empty || eng.shift_loaded)
                    && !eng.shifting
                    && !stop_req && !stop_out;
  assign stop_go = stop_req && eng.master && !eng.slave_busy
                   && (!eng.shifting || eng.byte_done || eng.rx_byte);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_out <= 1'b0;
    end else if (ce) begin
      stop_out <= on && stop_go && !eng.stop_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else if (ce) begin
      cmd.on <= !drop;
      cmd.issue_start <= on && start_go && !eng.start_done;
      cmd.issue_stop <= on && stop_go && !eng.stop_done;
      cmd.send_nak <= on && nak_req && !eng.nak_done;
    end
  end

  // ----------------------------------------------------------------
  // data holding register
  // ----------------------------------------------------------------
  // flush wins over a simultaneous engine load; a data write wins over both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= ibc_pkg::DATA_RESET;
      tx_empty <= 1'b1;
    end else if (ce) begin
      if (wr_data) begin
        data_reg <= wb;
        tx_empty <= 1'b0;
      end else if (wr_ctrl && wb[ibc_pkg::CTL_FLUSH]) begin
        data_reg <= ibc_pkg::DATA_RESET;
        tx_empty <= 1'b1;
      end else if (eng.load) begin
        tx_empty <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= ibc_pkg::DATA_RESET;
      tx_full <= 1'b0;
    end else if (ce) begin
      tx_data <= data_reg;
      tx_full <= !tx_empty && !(wr_ctrl && wb[ibc_pkg::CTL_FLUSH]) && !eng.load;
    end
  end

  // ----------------------------------------------------------------
  // rate generator as a timer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reload <= ibc_pkg::RATE_RESET;
    end else if (ce && wr) begin
      if (idx == ibc_pkg::IDX_RATE_HI) begin
        rate_reload[15:8] <= wb;
      end
      if (idx == ibc_pkg::IDX_RATE_LO) begin
        rate_reload[7:0] <= wb;
      end
    end
  end

  // a reload of zero wraps through ffff and so gives 65536 counts
  logic timer_run, timer_hit;
  assign timer_run = !on && tsel;
  assign timer_hit = timer_run && (rate_cnt == 16'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_cnt <= ibc_pkg::RATE_RESET;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= timer_hit;
      if (!timer_run || timer_hit) begin
        rate_cnt <= rate_reload;
      end else begin
        rate_cnt <= rate_cnt - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers and spike filters
  // ----------------------------------------------------------------
  logic [1:0] sda_sync, scl_sync;
  logic [FILT_STAGES-1:0] sda_sh, scl_sh;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync <= 2'b11;
      scl_sync <= 2'b11;
    end else if (ce) begin
      sda_sync <= {sda_sync[0], sda_pin};
      scl_sync <= {scl_sync[0], scl_pin};
    end
  end

  // output follows only when the whole window agrees, so a level that
  // lasts a single sample never gets through; costs three cycles of lag
  function automatic logic agree(input logic [FILT_STAGES-1:0] s);
    agree = (s == '0) || (s == '1);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sh <= '1;
      scl_sh <= '1;
      sda_filt <= 1'b1;
      scl_filt <= 1'b1;
    end else if (ce) begin
      sda_sh <= {sda_sh[FILT_STAGES-2:0], sda_sync[1]};
      scl_sh <= {scl_sh[FILT_STAGES-2:0], scl_sync[1]};
      if (filt_on) begin
        if (agree(sda_sh)) begin
          sda_filt <= sda_sh[FILT_STAGES-1];
        end
        if (agree(scl_sh)) begin
          scl_filt <= scl_sh[FILT_STAGES-1];
        end
      end else begin
        sda_filt <= sda_sync[1];
        scl_filt <= scl_sync[1];
      end
    end
  end

  // clock-line edge finder on the filtered copy
  logic scl_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev <= 1'b1;
      scl_rise <= 1'b0;
    end else if (ce) begin
      scl_prev <= scl_filt;
      scl_rise <= scl_filt && !scl_prev;
    end
  end

  // ----------------------------------------------------------------
  // arbitration lost
  // ----------------------------------------------------------------
  logic arb_event;
  assign arb_event = (on && eng.master && eng.sda_drive && !sda_filt && scl_filt && !scl_prev)
                     || (on && start_in_slave);

  // set wins over the read that clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_lost <= 1'b0;
    end else if (ce) begin
      if (arb_event) begin
        arb_lost <= 1'b1;
      end else if (rd_istat) begin
        arb_lost <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // events, mask and interrupt
  // ----------------------------------------------------------------
  logic [ibc_pkg::EV_W-1:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[ibc_pkg::EV_TXE] = on && tx_empty_irq_enable && tx_empty;
    ev_set[ibc_pkg::EV_ARB] = arb_event;
    ev_set[ibc_pkg::EV_TICK] = timer_hit;
    ev_set[ibc_pkg::EV_START] = eng.start_done;
    ev_set[ibc_pkg::EV_STOP] = eng.stop_done;
    ev_set[ibc_pkg::EV_NAK] = eng.nak_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev <= ibc_pkg::EV_RESET;
    end else if (ce) begin
      ev <= (rd_event ? '0 : ev) | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_mask <= ibc_pkg::MASK_RESET;
    end else if (ce && wr && (idx == ibc_pkg::IDX_MASK)) begin
      ev_mask <= wb[ibc_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((rd_event ? '0 : ev) | ev_set) & ev_mask);
    end
  end

endmodule

/* ibc_bus_control_sva.sv */
// checker for the bus control block: requests, data holding and timer
// sees only top-level ports; bound to every instance at the foot of the file
`timescale 1ns/100ps
module ibc_bus_control_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire ibc_pkg::ibc_eng_t eng,
  input wire ibc_pkg::ibc_cmd_t cmd,
  input wire logic tx_full,
  input wire logic tick
);
  localparam logic [15:0] A_DATA = {2'b00, ibc_pkg::IDX_DATA, 2'b00};
  localparam logic [15:0] A_CTRL = {2'b00, ibc_pkg::IDX_CTRL, 2'b00};
  logic wr_go;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // committed write: registers only change at this edge
  assign wr_go = psel && penable && pready && pwrite;
  property p_off_idle;
    !cmd.on |=> !cmd.issue_start && !cmd.issue_stop && !cmd.send_nak;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("command while off");
  property p_start_drop;
    cmd.issue_start && eng.start_done |=> !cmd.issue_start;
  endproperty
  a_start_drop: assert property (p_start_drop) else $error("start held");
  property p_start_byte;
    $rose(cmd.issue_start) |-> (tx_full || $past(eng.shift_loaded)) && !$past(eng.shifting);
  endproperty
  a_start_byte: assert property (p_start_byte) else $error("start early");
  property p_stop_first;
    $rose(cmd.issue_start) |-> !cmd.issue_stop;
  endproperty
  a_stop_first: assert property (p_stop_first) else $error("start over stop");
  property p_slave_start;
    (eng.slave_busy && !eng.master) [*2] |-> !cmd.issue_start && !cmd.issue_stop;
  endproperty
  a_slave_start: assert property (p_slave_start) else $error("request in slave");
  property p_stop_go;
    $rose(cmd.issue_stop) |-> $past(eng.master);
  endproperty
  a_stop_go: assert property (p_stop_go) else $error("stop not master");
  property p_stop_drop;
    cmd.issue_stop && eng.stop_done |=> !cmd.issue_stop;
  endproperty
  a_stop_drop: assert property (p_stop_drop) else $error("stop held");
  property p_nak_drop;
    cmd.send_nak && eng.nak_done |-> ##2 !cmd.send_nak;
  endproperty
  a_nak_drop: assert property (p_nak_drop) else $error("nak held");
  property p_data_full;
    wr_go && paddr == A_DATA |-> ##2 tx_full;
  endproperty
  a_data_full: assert property (p_data_full) else $error("data not held");
  property p_flush;
    wr_go && paddr == A_CTRL && pwdata[1] |=> !tx_full;
  endproperty
  a_flush: assert property (p_flush) else $error("flush ignored");
  property p_tick_on;
    cmd.on && $past(cmd.on) |-> !tick;
  endproperty
  a_tick_on: assert property (p_tick_on) else $error("tick while on");
endmodule
bind ibc_bus_control ibc_bus_control_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .eng(eng), .cmd(cmd), .tx_full(tx_full),
  .tick(tick));

/* ibc_eng_model.sv */
// bus engine stand-in: answers start, stop and nak after lat+1 cycles
// assumes pclk shared with the block; never shifts, lat is at least one
`timescale 1ns/100ps
module ibc_eng_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire ibc_pkg::ibc_cmd_t cmd,
  input wire logic [7:0] lat,
  input wire logic slave_busy,
  output ibc_pkg::ibc_eng_t eng
);
  logic [7:0] cnt;
  logic busy;
  assign busy = cmd.issue_start || cmd.issue_stop || cmd.send_nak;
  // one command at a time; count restarts on each done so a late drop is not served twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng <= '0;
      cnt <= 8'h00;
    end else begin
      eng.start_done <= 1'b0;
      eng.stop_done <= 1'b0;
      eng.nak_done <= 1'b0;
      eng.rx_byte <= 1'b0;
      eng.slave_busy <= slave_busy;
      eng.sda_drive <= 1'b1;
      if (!busy || eng.start_done || eng.stop_done || eng.nak_done) begin
        cnt <= 8'h00;
      end else if (cnt != lat) begin
        cnt <= cnt + 8'h01;
      end else if (cmd.issue_stop) begin
        eng.stop_done <= 1'b1;
        eng.master <= 1'b0;
      end else if (cmd.issue_start) begin
        eng.start_done <= 1'b1;
        eng.master <= 1'b1;
      end else begin
        eng.nak_done <= 1'b1;
        eng.rx_byte <= 1'b1;
      end
    end
  end
endmodule

/* tb_top.sv */
// self-checking bench for the bus control block over apb
// assumes the engine model on the far side and pins driven by the bench
`timescale 1ns/100ps
module tb_top;
  localparam logic [15:0] A_DATA = {2'b00, ibc_pkg::IDX_DATA, 2'b00};
  localparam logic [15:0] A_ISTAT = {2'b00, ibc_pkg::IDX_ISTAT, 2'b00};
  localparam logic [15:0] A_CTRL = {2'b00, ibc_pkg::IDX_CTRL, 2'b00};
  localparam logic [15:0] A_RLO = {2'b00, ibc_pkg::IDX_RATE_LO, 2'b00};
  localparam logic [15:0] A_EVT = {2'b00, ibc_pkg::IDX_EVENT, 2'b00};
  localparam logic [15:0] A_MASK = {2'b00, ibc_pkg::IDX_MASK, 2'b00};
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, sda_pin, scl_pin;
  logic sda_filt, scl_filt, scl_rise, tick, irq, tx_full, slave_busy, slverr, seen;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [7:0] tx_data, lat, c;
  ibc_pkg::ibc_eng_t eng;
  ibc_pkg::ibc_cmd_t cmd;
  int n_fail, cmp_count, cyc, n_tick, n_rise, t0, lo, lf;
  logic [7:0] t0_tab [4] = '{8'h80, 8'hE6, 8'h80, 8'h00};
  ibc_bus_control dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng(eng), .cmd(cmd),
    .tx_data(tx_data), .tx_full(tx_full), .sda_pin(sda_pin), .scl_pin(scl_pin), .sda_filt(sda_filt),
    .scl_filt(scl_filt), .scl_rise(scl_rise), .tick(tick), .irq(irq));
  ibc_eng_model u_eng (.pclk(pclk), .presetn(presetn), .cmd(cmd), .lat(lat), .slave_busy(slave_busy), .eng(eng));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected control readback; requests stick only if on before and after
  function automatic logic [7:0] ctl_next(input logic [7:0] o, input logic [7:0] w);
    return (w & 8'h99) | ((w[7] && o[7]) ? ((o | w) & 8'h64) : 8'h00);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one apb transfer, request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_done(input int k);
    for (int n = 0; n < 60 && !(k ? eng.stop_done : eng.start_done); n++) begin
      if (eng.stop_done) seen = 1'b1;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
  // pin-to-output lag of a held low level on the data line
  task automatic lag(output int l);
    sda_pin <= 1'b0;
    for (l = 0; l < 20 && sda_filt !== 1'b0; l++) @(posedge pclk);
    sda_pin <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  task automatic spike(output logic low);
    low = 1'b0;
    sda_pin <= 1'b0;
    @(posedge pclk);
    sda_pin <= 1'b1;
    repeat (12) begin
      @(posedge pclk);
      if (sda_filt !== 1'b1) low = 1'b1;
    end
  endtask
  // cycle budget and pulse counters
  always @(posedge pclk) begin
    cyc++;
    if (tick === 1'b1) n_tick++;
    if (scl_rise === 1'b1) n_rise++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, slave_busy} = '0;
    {ce, sda_pin, scl_pin} = 3'b111;
    seed = 32'h1328;
    lat = 8'hC8;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, A_CTRL, 0);
    chk(q, 32'h0);
    apb(0, A_CTRL + 16'h000C, 0);
    chk(q, 0);
    chk(slverr, 1);
    // requests stick against zero writes and drop with the enable bit
    c = 8'h00;
    foreach (t0_tab[i]) begin
      apb(1, A_CTRL, t0_tab[i]);
      c = ctl_next(c, t0_tab[i]);
      apb(0, A_CTRL, 0);
      chk(q, c);
      chk(cmd.issue_start, 0);
    end
    seed = xs(seed);
    lat <= seed[7:0] % 8'h08 + 8'h01;
    apb(1, A_MASK, 32'h8);
    apb(1, A_CTRL, 32'h80);
    apb(1, A_CTRL, 32'hC0);
    seed = xs(seed);
    apb(1, A_DATA, seed);
    @(posedge pclk);
    chk({tx_full, tx_data}, {1'b1, seed[7:0]});
    wait_done(0);
    apb(0, A_CTRL, 0);
    chk(q, 32'h80);
    chk(irq, 1);
    apb(0, A_EVT, 0);
    repeat (2) @(posedge pclk);
    chk({q[3], irq}, 2'b10);
    seen = 1'b0;
    apb(1, A_CTRL, 32'hE0);
    wait_done(0);
    chk(seen, 1);
    apb(1, A_CTRL, 32'hA0);
    wait_done(1);
    apb(0, A_CTRL, 0);
    chk(q, 32'h80);
    // slave transaction under way: both requests refused
    slave_busy <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1, A_CTRL, 32'hE0);
    repeat (4) @(posedge pclk);
    apb(0, A_CTRL, 0);
    chk(q, 32'h80);
    apb(0, A_ISTAT, 0);
    chk(q[2], 1);
    apb(0, A_ISTAT, 0);
    chk(q[2], 0);
    slave_busy <= 1'b0;
    // flush and the empty interrupt gate
    apb(1, A_MASK, 32'h1);
    apb(1, A_CTRL, 32'h82);
    chk(tx_full, 0);
    apb(0, A_ISTAT, 0);
    chk(q[7], 1);
    apb(0, A_EVT, 0);
    chk({q[0], irq}, 0);
    // nak request drops on its own once the engine has sent it
    apb(1, A_CTRL, 32'h84);
    repeat (20) @(posedge pclk);
    apb(0, A_CTRL, 0);
    chk(q, 32'h80);
    apb(1, A_CTRL, 32'h88);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    // rate generator as a timer only while off
    seed = xs(seed);
    apb(1, A_RLO - 16'h4, 0);
    apb(1, A_RLO, seed[2:0] + 8'h04);
    apb(1, A_CTRL, 32'h10);
    t0 = n_tick;
    repeat (100) @(posedge pclk);
    chk(n_tick > t0, 1);
    apb(1, A_CTRL, 32'h90);
    @(posedge pclk);
    t0 = n_tick;
    repeat (100) @(posedge pclk);
    chk(n_tick, t0);
    // input filters: lag, spike rejection, link clock edges
    apb(1, A_CTRL, 32'h0);
    lag(lo);
    spike(seen);
    chk(seen, 1);
    apb(1, A_CTRL, 32'h1);
    lag(lf);
    chk(lf, lo + ibc_pkg::FILT_LAG_CYC);
    spike(seen);
    chk(seen, 0);
    t0 = n_rise;
    repeat (8) begin
      scl_pin <= ~scl_pin;
      repeat (8) @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
    chk(n_rise - t0, 4);
    end_of_test;
  end
endmodule
